// *** hdl/wd_postscaler.sv ***
// Postscaler counter with a power-of-two terminal count
`timescale 1ns/1ps
module wd_postscaler
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic restart,
  input wire logic tick,
  input wire logic [PostSelWidth-1:0] select,
  // Status
  output logic [PostWidth-1:0] count,
  output logic expire,
  output logic windowOpen
);

  logic [PostWidth-1:0] lastCount;
  logic [PostWidth-1:0] quarterStart;

  // Code n divides by two to the n
  assign lastCount = PostWidth'((17'h1 << select) - 17'h1);
  // Final quarter of the period begins at three quarters of the ratio; codes 0 and 1 leave the whole period open
  assign quarterStart = (select < 4'h2) ? PostReset : PostWidth'((17'h3 << select) >> 2);
  assign expire = tick && (count == lastCount);
  assign windowOpen = (count >= quarterStart);

  always_ff @(posedge clock) begin
    if (reset || restart || expire) begin
      count <= PostReset;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

endmodule // wd_postscaler

// *** hdl/wdt_pkg.sv ***
// Package of constants and types for the windowed watchdog timer
package wdt_pkg;

  // =====================================================
  // Fuse word layout
  localparam int PostSelLsb = 0;
  localparam int PostSelWidth = 4;
  localparam int PreSelBit = 4;
  localparam int WindowDisableBit = 6;
  localparam int AlwaysEnableBit = 7;
  localparam int FuseWidth = 8;

  // =====================================================
  // Reset-control register bit positions
  localparam int IdleFlagBit = 2;
  localparam int SleepFlagBit = 3;
  localparam int TimeoutFlagBit = 4;
  localparam int SwEnableBit = 5;

  // =====================================================
  // Timing
  localparam int ClockHz = 125000000;
  localparam int RcClockHz = 32000;
  localparam int RcTickCycles = ClockHz / RcClockHz;
  localparam logic [11:0] RcTickLast = 12'(RcTickCycles - 1);
  localparam logic [6:0] PreLast32 = 7'h1f;
  localparam logic [6:0] PreLast128 = 7'h7f;
  localparam int PostWidth = 16;

  // =====================================================
  // Reset values
  localparam logic [11:0] RcDivReset = 12'h000;
  localparam logic [6:0] PreReset = 7'h00;
  localparam logic [PostWidth-1:0] PostReset = 16'h0000;

  // =====================================================
  // Types
  typedef enum logic [1:0] {RunMode, SleepMode, IdleMode} power_mode_t;

  typedef struct packed {
    logic alwaysEnable;
    logic windowDisable;
    logic prescaleSelect;
    logic [PostSelWidth-1:0] postscaleSelect;
  } fuse_fields_t;

  typedef struct packed {
    logic clearInstr;
    logic sleepInstr;
    logic idleInstr;
    logic wakeOther;
    logic clockSwitchDone;
  } core_events_t;

endpackage

// *** hdl/windowed_watchdog_timer.sv ***
// Windowed watchdog timer with prescaler, postscaler and status flags
// Summary of operation
// - Watchdog ticks from a 32 kHz low-power RC clock, enabled with the watchdog.
// - Prescaler divides the RC clock by 32 or 128 per fuse.
// - Base timeout is 1 ms for divide-by-32, 4 ms for divide-by-128.
// - Four-bit fuse field picks one of 16 postscaler ratios up to 32768.
// - Any device reset clears counter, prescaler and postscaler.
// - Completion of a clock switch clears counter, prescaler and postscaler.
// - Entering and leaving Sleep or Idle clears all counts.
// - The clear instruction in normal operation clears all counts.
// - An enabled watchdog keeps counting in Sleep and Idle.
// - Timeout in Sleep or Idle wakes core; power-save flags stay set.
// - Timeout sets a sticky flag that only software or a device reset clears.
// - Always-enable fuse forces the watchdog on regardless of software.
// - Otherwise the software-enable bit turns the watchdog on or off.
// - Device reset clears the software-enable bit.
// - Early clear in window mode causes a watchdog reset.
// - Prescale fuse 1 selects divide by 128, 0 selects divide by 32.
// - Postscale code 1111 is 1:32768 and 1110 is 1:16384.
// - Window-disable fuse 1 is non-window mode, 0 is window mode.
`timescale 1ns/1ps
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration fuses
  input wire fuse_fields_t fuses,
  // Core events, one-cycle pulses
  input wire core_events_t events,
  // Software writes to the reset-control bits
  input wire logic swEnableSet,
  input wire logic swEnableClear,
  input wire logic timeoutFlagClear,
  input wire logic sleepFlagClear,
  input wire logic idleFlagClear,
  // Status and actions
  output logic [5:0] resetControlReg,
  output logic lowPowerRcEnable,
  output logic watchdogReset,
  output logic wakeRequest,
  output logic [1:0] powerMode
);

  logic swEnable_reg;
  logic timeoutFlag_reg;
  logic sleepFlag_reg;
  logic idleFlag_reg;
  logic rcEnable_reg;
  logic wdReset_reg;
  logic wake_reg;
  power_mode_t mode_reg;
  logic [11:0] rcDiv_reg;
  logic [6:0] pre_reg;
  logic wdEnable;
  logic rcTick;
  logic preTick;
  logic restart;
  logic exitPowerSave;
  logic timeout;
  logic earlyClear;
  logic normalClear;
  logic [PostWidth-1:0] postCount;
  logic windowOpen;
  logic [6:0] preLast;

  // =====================================================
  // Enable and restart sources
  assign wdEnable = fuses.alwaysEnable | swEnable_reg;
  assign normalClear = events.clearInstr && (mode_reg == RunMode);
  assign exitPowerSave = (mode_reg != RunMode) && (events.wakeOther || timeout);
  assign restart = !wdEnable || events.clockSwitchDone
    || events.sleepInstr || events.idleInstr
    || exitPowerSave
    || normalClear;
  assign earlyClear = normalClear && !fuses.windowDisable && !windowOpen && wdEnable;

  // =====================================================
  // Low-power RC clock emulated as a tick every 1/32 kHz
  assign rcTick = wdEnable && (rcDiv_reg == RcTickLast);

  always_ff @(posedge clock) begin
    if (reset || restart || rcTick) begin
      rcDiv_reg <= RcDivReset;
    end else begin
      rcDiv_reg <= rcDiv_reg + 12'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rcEnable_reg <= 1'b0;
    end else begin
      rcEnable_reg <= wdEnable;
    end
  end

  // =====================================================
  // Prescaler
  assign preLast = fuses.prescaleSelect ? PreLast128 : PreLast32;
  assign preTick = rcTick && (pre_reg == preLast);

  always_ff @(posedge clock) begin
    if (reset || restart || preTick) begin
      pre_reg <= PreReset;
    end else if (rcTick) begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // =====================================================
  // Postscaler; counting continues in Sleep and Idle
  wd_postscaler postscaler (
    .clock(clock),
    .reset(reset),
    .restart(restart),
    .tick(preTick),
    .select(fuses.postscaleSelect),
    .count(postCount),
    .expire(timeout),
    .windowOpen(windowOpen)
  );

  // =====================================================
  // Power mode tracking
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_reg <= RunMode;
    end else if (exitPowerSave) begin
      mode_reg <= RunMode;
    end else if (mode_reg == RunMode && events.sleepInstr) begin
      mode_reg <= SleepMode;
    end else if (mode_reg == RunMode && events.idleInstr) begin
      mode_reg <= IdleMode;
    end
  end

  // =====================================================
  // Reset-control status and software-enable bits
  always_ff @(posedge clock) begin
    if (reset) begin
      swEnable_reg <= 1'b0;
    end else if (swEnableSet) begin
      swEnable_reg <= 1'b1;
    end else if (swEnableClear) begin
      swEnable_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      timeoutFlag_reg <= 1'b0;
    end else if (timeout) begin
      timeoutFlag_reg <= 1'b1;
    end else if (timeoutFlagClear) begin
      timeoutFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sleepFlag_reg <= 1'b0;
      idleFlag_reg <= 1'b0;
    end else begin
      if (mode_reg == RunMode && events.sleepInstr) begin
        sleepFlag_reg <= 1'b1;
      end else if (sleepFlagClear) begin
        sleepFlag_reg <= 1'b0;
      end
      if (mode_reg == RunMode && events.idleInstr && !events.sleepInstr) begin
        idleFlag_reg <= 1'b1;
      end else if (idleFlagClear) begin
        idleFlag_reg <= 1'b0;
      end
    end
  end

  // =====================================================
  // Actions: wake from power save, device reset from run mode
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_reg <= 1'b0;
      wdReset_reg <= 1'b0;
    end else begin
      wake_reg <= timeout && (mode_reg != RunMode);
      wdReset_reg <= (timeout && mode_reg == RunMode) || earlyClear;
    end
  end

  assign resetControlReg = {swEnable_reg, timeoutFlag_reg, sleepFlag_reg, idleFlag_reg, 2'b00};
  assign lowPowerRcEnable = rcEnable_reg;
  assign watchdogReset = wdReset_reg;
  assign wakeRequest = wake_reg;
  assign powerMode = mode_reg;

  // =====================================================
  // Assertions
  flag_sticky_a: assert property (@(posedge clock) disable iff (reset)
    timeout |=> timeoutFlag_reg)
    else $error("timeout flag not set after timeout");

  flag_hold_a: assert property (@(posedge clock) disable iff (reset)
    (timeoutFlag_reg && !timeoutFlagClear) |=> timeoutFlag_reg)
    else $error("timeout flag cleared without software");

  sw_enable_a: assert property (@(posedge clock)
    reset |=> !swEnable_reg)
    else $error("software enable not cleared by reset");

  always_on_a: assert property (@(posedge clock) disable iff (reset)
    fuses.alwaysEnable |=> rcEnable_reg)
    else $error("always-enable fuse did not keep watchdog on");

  disabled_idle_a: assert property (@(posedge clock) disable iff (reset)
    (!fuses.alwaysEnable && !swEnable_reg) [*2] |-> (rcDiv_reg == RcDivReset && pre_reg == PreReset))
    else $error("disabled watchdog is counting");

  clear_restart_a: assert property (@(posedge clock) disable iff (reset)
    (normalClear && !earlyClear) |=> (pre_reg == PreReset && postCount == PostReset))
    else $error("clear instruction did not restart counts");

  sleep_restart_a: assert property (@(posedge clock) disable iff (reset)
    events.sleepInstr |=> (rcDiv_reg == RcDivReset && pre_reg == PreReset))
    else $error("power save entry did not restart counts");

  switch_restart_a: assert property (@(posedge clock) disable iff (reset)
    events.clockSwitchDone |=> (pre_reg == PreReset && postCount == PostReset))
    else $error("clock switch did not restart counts");

  early_clear_a: assert property (@(posedge clock) disable iff (reset)
    earlyClear |=> watchdogReset)
    else $error("early clear did not reset device");

  wake_timeout_a: assert property (@(posedge clock) disable iff (reset)
    (timeout && mode_reg == SleepMode) |=> (wakeRequest && mode_reg == RunMode && sleepFlag_reg))
    else $error("timeout in sleep did not wake");

  run_timeout_a: assert property (@(posedge clock) disable iff (reset)
    (timeout && mode_reg == RunMode) |=> (watchdogReset && !wakeRequest))
    else $error("timeout in run did not reset device");

  pre_ratio_a: assert property (@(posedge clock) disable iff (reset)
    (preTick && !fuses.prescaleSelect) |-> pre_reg == 7'h1f)
    else $error("prescale divide by 32 wrong");

  pre_long_a: assert property (@(posedge clock) disable iff (reset)
    (preTick && fuses.prescaleSelect) |-> pre_reg == 7'h7f)
    else $error("prescale divide by 128 wrong");

  idle_restart_a: assert property (@(posedge clock) disable iff (reset)
    events.idleInstr |=> (rcDiv_reg == RcDivReset && pre_reg == PreReset))
    else $error("idle entry did not restart counts");

  wake_restart_a: assert property (@(posedge clock) disable iff (reset)
    exitPowerSave |=> (rcDiv_reg == RcDivReset && pre_reg == PreReset && postCount == PostReset))
    else $error("leaving power save did not restart counts");

  reset_counts_a: assert property (@(posedge clock)
    reset |=> (rcDiv_reg == RcDivReset && pre_reg == PreReset && postCount == PostReset))
    else $error("device reset did not clear counts");

  rc_follow_a: assert property (@(posedge clock) disable iff (reset)
    wdEnable |=> lowPowerRcEnable)
    else $error("rc clock not enabled with watchdog");

  post_max_a: assert property (@(posedge clock) disable iff (reset)
    (timeout && fuses.postscaleSelect == 4'hf) |-> postCount == 16'h7fff)
    else $error("postscale code 1111 ratio wrong");

  post_next_a: assert property (@(posedge clock) disable iff (reset)
    (timeout && fuses.postscaleSelect == 4'he) |-> postCount == 16'h3fff)
    else $error("postscale code 1110 ratio wrong");

  post_unit_a: assert property (@(posedge clock) disable iff (reset)
    (timeout && fuses.postscaleSelect == 4'h0) |-> postCount == 16'h0000)
    else $error("postscale code 0000 ratio wrong");

  window_clear_a: assert property (@(posedge clock) disable iff (reset)
    (normalClear && !timeout && (fuses.windowDisable || windowOpen)) |=> !watchdogReset)
    else $error("allowed clear caused a reset");

  disabled_quiet_a: assert property (@(posedge clock) disable iff (reset)
    (!fuses.alwaysEnable && !swEnable_reg) |=> (!watchdogReset && !wakeRequest))
    else $error("disabled watchdog acted");

  sleep_count_a: assert property (@(posedge clock) disable iff (reset)
    (mode_reg != RunMode && !restart && !rcTick) |=> rcDiv_reg == $past(rcDiv_reg) + 12'h001)
    else $error("watchdog stopped counting in power save");

  sleep_entry_a: assert property (@(posedge clock) disable iff (reset)
    (mode_reg == RunMode && events.sleepInstr) |=> (powerMode == 2'h1 && sleepFlag_reg))
    else $error("sleep entry not recorded");

  wake_idle_a: assert property (@(posedge clock) disable iff (reset)
    (timeout && mode_reg == IdleMode && idleFlag_reg && !idleFlagClear)
      |=> (wakeRequest && powerMode == 2'h0 && idleFlag_reg))
    else $error("timeout in idle did not wake");

  run_no_wake_a: assert property (@(posedge clock) disable iff (reset)
    (mode_reg == RunMode) |=> !wakeRequest)
    else $error("wake pulse outside power save");

  sleep_clear_a: assert property (@(posedge clock) disable iff (reset)
    (events.clearInstr && mode_reg != RunMode) |=> !watchdogReset)
    else $error("clear in power save caused a reset");

endmodule // windowed_watchdog_timer

// *** tb/core_model.sv ***
// Processor core model issuing watchdog instructions and status writes
`timescale 1ns/1ps
module core_model
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Watchdog side
  input wire logic wakeRequest,
  output core_events_t events,
  output logic [4:0] swWrite,
  output logic resumed
);
  initial begin
    events = '0;
    swWrite = '0;
  end

  // ==========================================
  // One-cycle instruction and write pulse
  task automatic send(input core_events_t ev, input logic [4:0] sw);
    @(negedge clock);
    events = ev; // Clears only when commanded
    swWrite = sw; // Software-enable set and clear, and flags cleared by software
    @(negedge clock);
    events = '0;
    swWrite = '0;
  endtask

  // ==========================================
  // Resume after a wake
  always @(posedge clock) begin
    if (reset) begin
      resumed <= 1'b0;
    end else if (wakeRequest) begin
      resumed <= 1'b1;
    end
  end
endmodule // core_model

// *** tb/windowed_watchdog_timer_tb.sv ***
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module windowed_watchdog_timer_tb
  import wdt_pkg::*;
();
  typedef struct packed {
    fuse_fields_t f;
    core_events_t e;
    logic [4:0] sw;
    logic wdReset;
    logic [5:0] reset_control_reg;
    logic rcEn;
    logic [1:0] mode;
  } row_t;
  localparam fuse_fields_t FuseSw = '{alwaysEnable: 1'b0, windowDisable: 1'b0,
    prescaleSelect: 1'b0, postscaleSelect: 4'h2};
  localparam fuse_fields_t FuseNoWin = '{alwaysEnable: 1'b0, windowDisable: 1'b1,
    prescaleSelect: 1'b0, postscaleSelect: 4'h2};
  localparam fuse_fields_t FuseWinOpen = '{alwaysEnable: 1'b0, windowDisable: 1'b0,
    prescaleSelect: 1'b0, postscaleSelect: 4'h0};
  localparam fuse_fields_t FuseAlways = '{alwaysEnable: 1'b1, windowDisable: 1'b1,
    prescaleSelect: 1'b0, postscaleSelect: 4'h0};
  localparam fuse_fields_t FuseTimeout = '{alwaysEnable: 1'b0, windowDisable: 1'b1,
    prescaleSelect: 1'b0, postscaleSelect: 4'h0};
  localparam int TimeoutLo = 31 * RcTickCycles;
  localparam int TimeoutHi = 33 * RcTickCycles;
  localparam row_t Rows [13] = '{
    '{FuseSw, 5'h00, 5'h00, 1'b0, 6'h00, 1'b0, 2'h0},
    '{FuseSw, 5'h00, 5'h10, 1'b0, 6'h20, 1'b1, 2'h0},
    '{FuseSw, 5'h10, 5'h00, 1'b1, 6'h20, 1'b1, 2'h0},
    '{FuseNoWin, 5'h10, 5'h00, 1'b0, 6'h20, 1'b1, 2'h0},
    '{FuseWinOpen, 5'h10, 5'h00, 1'b0, 6'h20, 1'b1, 2'h0},
    '{FuseSw, 5'h08, 5'h00, 1'b0, 6'h28, 1'b1, 2'h1},
    '{FuseSw, 5'h10, 5'h00, 1'b0, 6'h28, 1'b1, 2'h1},
    '{FuseSw, 5'h02, 5'h00, 1'b0, 6'h28, 1'b1, 2'h0},
    '{FuseSw, 5'h04, 5'h00, 1'b0, 6'h2c, 1'b1, 2'h2},
    '{FuseSw, 5'h02, 5'h03, 1'b0, 6'h20, 1'b1, 2'h0},
    '{FuseSw, 5'h00, 5'h08, 1'b0, 6'h00, 1'b0, 2'h0},
    '{FuseAlways, 5'h00, 5'h08, 1'b0, 6'h00, 1'b1, 2'h0},
    '{FuseSw, 5'h01, 5'h00, 1'b0, 6'h00, 1'b0, 2'h0}
  };

  logic clock;
  logic reset;
  fuse_fields_t fuses;
  core_events_t events;
  logic [4:0] swWrite;
  logic [5:0] resetControlReg;
  logic lowPowerRcEnable;
  logic watchdogReset;
  logic wakeRequest;
  logic [1:0] powerMode;
  logic resumed;
  int nMismatch;
  int testsRun;
  int waitCount;

  windowed_watchdog_timer dut (
    .clock(clock), .reset(reset), .fuses(fuses), .events(events),
    .swEnableSet(swWrite[4]), .swEnableClear(swWrite[3]), .timeoutFlagClear(swWrite[2]),
    .sleepFlagClear(swWrite[1]), .idleFlagClear(swWrite[0]),
    .resetControlReg(resetControlReg), .lowPowerRcEnable(lowPowerRcEnable),
    .watchdogReset(watchdogReset), .wakeRequest(wakeRequest), .powerMode(powerMode)
  );
  core_model core (
    .clock(clock), .reset(reset), .wakeRequest(wakeRequest),
    .events(events), .swWrite(swWrite), .resumed(resumed)
  );

  always #4 clock = ~clock;

  // ==========================================
  // Compare and report
  task automatic check_word(input logic [5:0] got, input logic [5:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({5'h00, got}, {5'h00, exp}, what);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic run_row(input row_t r);
    @(negedge clock);
    fuses = r.f;
    core.send(r.e, r.sw);
    check_bit(watchdogReset, r.wdReset, "reset pulse");
    @(negedge clock);
    check_word(resetControlReg, r.reset_control_reg, "status bits");
    check_bit(lowPowerRcEnable, r.rcEn, "rc enable");
    check_word({4'h0, powerMode}, {4'h0, r.mode}, "power mode");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    fuses = FuseSw;
    nMismatch = 0;
    testsRun = 0;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    foreach (Rows[i]) run_row(Rows[i]);
    $display("test table done");
    core.send(5'h00, 5'h10);
    @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check_word(resetControlReg, 6'h00, "status after reset");
    $display("test reset done");
    fuses = FuseTimeout;
    core.send(5'h00, 5'h10);
    core.send(5'h08, 5'h00);
    waitCount = 0;
    while (wakeRequest !== 1'b1 && waitCount < TimeoutHi) begin
      @(negedge clock);
      waitCount++;
    end
    if (waitCount >= TimeoutHi) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: no wake from sleep", $time);
    end else begin
      check_bit(waitCount >= TimeoutLo, 1'b1, "timeout too early");
      check_bit(watchdogReset, 1'b0, "reset in sleep");
      @(negedge clock);
      check_bit(wakeRequest, 1'b0, "wake pulse length");
      check_bit(resumed, 1'b1, "core resumed");
      check_word(resetControlReg, 6'h38, "flags after wake");
      check_word({4'h0, powerMode}, 6'h00, "mode after wake");
      repeat (4) @(negedge clock);
      check_word(resetControlReg, 6'h38, "sticky flag");
      core.send(5'h00, 5'h04);
      @(negedge clock);
      check_word(resetControlReg, 6'h28, "flag cleared");
      $display("test timeout done");
    end
    results();
  end
endmodule // windowed_watchdog_timer_tb
